//--- rtl/sllb_defs.svh
// register offsets, field positions, reset values and timing counts for link bring-up
`ifndef SLLB_DEFS_SVH
`define SLLB_DEFS_SVH
`define SLLB_OFF_SYNC_CTRL 12'h03a
`define SLLB_OFF_SYNC_STAT 12'h03b
`define SLLB_OFF_EQ 12'h268
`define SLLB_OFF_PLL_EN 12'h280
`define SLLB_OFF_PLL_LOCK 12'h281
`define SLLB_OFF_VARACTOR 12'h2a0
`define SLLB_OFF_LINK_EN 12'h300
`define SLLB_OFF_SUBCLASS 12'h301
`define SLLB_OFF_MF_DEL_LO 12'h304
`define SLLB_OFF_MF_DEL_HI 12'h305
`define SLLB_OFF_MF_VAR_LO 12'h306
`define SLLB_OFF_MF_VAR_HI 12'h307
`define SLLB_OFF_XBAR0 12'h308
`define SLLB_OFF_XBAR3 12'h30b
`define SLLB_OFF_POLARITY 12'h334
`define SLLB_PLL_ON_VAL 8'h01
`define SLLB_SYNC_ONESHOT 8'h01
`define SLLB_SYNC_ENABLE 8'h81
`define SLLB_SYNC_ARM 8'hc1
`define SLLB_EQ_REQ_VAL 6'h22
`define SLLB_EQ_RESET 8'h22
`define SLLB_VARACTOR_VAL 8'h06
`define SLLB_LINKS_DUAL 2'h3
`define SLLB_LINKS_SINGLE 2'h1
`define SLLB_LOCK_BIT 3
`define SLLB_STATUS_LINK_BIT 2
`define SLLB_TWO_LINK_BIT 3
`define SLLB_SYNC_EN_BIT 7
`define SLLB_SYNC_ARM_BIT 6
// serial-lane pll lock time, figure in ns, and cycles at 8 ns
`define SLLB_PLL_LOCK_NS 200
`define SLLB_CLK_NS 8
`define SLLB_PLL_LOCK_CYC ((`SLLB_PLL_LOCK_NS + `SLLB_CLK_NS - 1) / `SLLB_CLK_NS)
// host apb map
`define SLLB_APB_CMD 12'h000
`define SLLB_APB_STAT 12'h004
`define SLLB_APB_LINKCFG 12'h008
`define SLLB_APB_LANECFG 12'h00c
`define SLLB_APB_XBAR 12'h010
`define SLLB_APB_RDADDR 12'h014
`define SLLB_APB_RDDATA 12'h018
`endif

//--- rtl/sllb_pkg.sv
// types shared by both ends of the link bring-up block
package sllb_pkg;
    typedef logic [11:0] sllb_addr_type;
    typedef logic [7:0] sllb_byte_type;
    typedef logic [7:0] sllb_lanes_type;
endpackage

//--- rtl/sllb_if.sv
// register port and link pins between the converter and its host controller
`timescale 1ns/1ns
interface sllb_if;
    import sllb_pkg::*;
    logic req;
    logic wr;
    sllb_addr_type addr;
    sllb_byte_type wdata;
    logic ack;
    sllb_byte_type rdata;
    logic sysref;
    sllb_lanes_type lane_data;
    modport device (input req, input wr, input addr, input wdata, input sysref,
        input lane_data, output ack, output rdata);
    modport host (output req, output wr, output addr, output wdata, output sysref,
        output lane_data, input ack, input rdata);
endinterface

//--- rtl/sllb_device.sv
// converter end: link-layer configuration registers, pll lock and frame sync machine
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
`include "sllb_defs.svh"

// Behaviour
// - writing 0x01 at lane_pll_enable enables lane pll
// - pll lock reported in lane_pll_lock_status bit 0
// - host writes 0x22 in equalizer low bits
// - equalizer bits 7:6 select lane equalization
// - host writes 0x06 into varactor register
// - 0x01 at frame_sync_control selects one-shot sync
// - 0x81 enables, 0xc1 arms sync machine
// - sysref edge delivered after arming
// - sync lock sets frame_sync_status bit 3
// - polarity mask bit inverts logical lane
// - crossbar registers remap physical to logical
// - link enable field: 3 dual, 1 single
// - bit 2 of link_enable_control picks status link
module sllb_device (
    input wire logic pclk,
    input wire logic presetn,
    sllb_if.device bus,
    output logic [7:0] lane_out,
    output logic [1:0] link_enable_mask,
    output logic [1:0] equalizer_setting,
    output logic pll_enabled,
    output logic pll_locked,
    output logic sync_locked
);
    import sllb_pkg::*;

    typedef enum logic [3:0] {
        SY_IDLE = 4'b0001,
        SY_ENABLED = 4'b0010,
        SY_ARMED = 4'b0100,
        SY_LOCKED = 4'b1000
    } sllb_sync_type;

    typedef struct packed {
        sllb_byte_type sync_ctrl;
        sllb_byte_type eq;
        sllb_byte_type pll_en;
        sllb_byte_type varactor;
        sllb_byte_type link_en;
        sllb_byte_type subclass;
        sllb_byte_type mf_del_lo;
        sllb_byte_type mf_del_hi;
        sllb_byte_type mf_var_lo;
        sllb_byte_type mf_var_hi;
        logic [31:0] xbar;
        sllb_lanes_type polarity;
        logic [7:0] lock_cnt;
        logic pll_lock;
        sllb_sync_type sync;
        logic [2:0] sysref_sync;
        logic sysref_seen;
        logic ack;
        sllb_byte_type rdata;
        sllb_lanes_type lane_out;
    } sllb_dev_state_type;

    sllb_dev_state_type st_q;
    sllb_dev_state_type st_d;

    // crossbar: logical lane n takes physical lane held in the low 3 bits of its 4-bit slot
    function automatic sllb_lanes_type remap(input sllb_lanes_type phys,
        input logic [31:0] map);
        sllb_lanes_type r;
        r = 8'h00;
        for (int n = 0; n < 8; n++) begin
            r[n] = phys[map[n*4 +: 3]];
        end
        return r;
    endfunction

    // lane inputs synchronised per lane through three stages, kept outside the struct
    logic [7:0] lane_s1_q;
    logic [7:0] lane_s2_q;
    logic [7:0] lane_s3_q;
    logic [7:0] lane_stable_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane_s1_q <= 8'h00;
            lane_s2_q <= 8'h00;
            lane_s3_q <= 8'h00;
            lane_stable_q <= 8'h00;
        end else begin
            lane_s1_q <= bus.lane_data;
            lane_s2_q <= lane_s1_q;
            lane_s3_q <= lane_s2_q;
            for (int i = 0; i < 8; i++) begin
                if (lane_s2_q[i] == lane_s3_q[i]) begin
                    lane_stable_q[i] <= lane_s3_q[i];
                end
            end
        end
    end
    always_comb begin
        logic wr_now;
        logic sysref_rise;
        wr_now = 1'b0;
        sysref_rise = 1'b0;
        st_d = st_q;
        st_d.ack = 1'b0;
        st_d.sysref_sync = {st_q.sysref_sync[1:0], bus.sysref};
        // a level counts once flops two and three agree; sysref_seen holds it
        sysref_rise = (st_q.sysref_sync[2:1] == 2'b11) && !st_q.sysref_seen;
        wr_now = bus.req && bus.wr && !st_q.ack;
        // ----------------------------------------------------------------
        // register port: one-cycle ack after a request
        // ----------------------------------------------------------------
        if (bus.req && !st_q.ack) begin
            st_d.ack = 1'b1;
            st_d.rdata = 8'h00;
            if (bus.wr) begin
                unique case (bus.addr)
                    `SLLB_OFF_SYNC_CTRL: st_d.sync_ctrl = bus.wdata;
                    `SLLB_OFF_EQ: st_d.eq = bus.wdata;
                    `SLLB_OFF_PLL_EN: st_d.pll_en = bus.wdata;
                    `SLLB_OFF_VARACTOR: st_d.varactor = bus.wdata;
                    `SLLB_OFF_LINK_EN: st_d.link_en = bus.wdata;
                    `SLLB_OFF_SUBCLASS: st_d.subclass = bus.wdata;
                    `SLLB_OFF_MF_DEL_LO: st_d.mf_del_lo = bus.wdata;
                    `SLLB_OFF_MF_DEL_HI: st_d.mf_del_hi = bus.wdata;
                    `SLLB_OFF_MF_VAR_LO: st_d.mf_var_lo = bus.wdata;
                    `SLLB_OFF_MF_VAR_HI: st_d.mf_var_hi = bus.wdata;
                    `SLLB_OFF_POLARITY: st_d.polarity = bus.wdata;
                    default: begin
                        if (bus.addr >= `SLLB_OFF_XBAR0 && bus.addr <= `SLLB_OFF_XBAR3) begin
                            st_d.xbar[bus.addr[1:0]*8 +: 8] = bus.wdata;
                        end
                    end
                endcase
            end else begin
                unique case (bus.addr)
                    `SLLB_OFF_SYNC_CTRL: st_d.rdata = st_q.sync_ctrl;
                    `SLLB_OFF_SYNC_STAT: begin
                        st_d.rdata = 8'h00;
                        st_d.rdata[`SLLB_LOCK_BIT] = (st_q.sync == SY_LOCKED);
                    end
                    `SLLB_OFF_EQ: st_d.rdata = st_q.eq;
                    `SLLB_OFF_PLL_EN: st_d.rdata = st_q.pll_en;
                    `SLLB_OFF_PLL_LOCK: st_d.rdata = {7'h00, st_q.pll_lock};
                    `SLLB_OFF_VARACTOR: st_d.rdata = st_q.varactor;
                    // link enable readback returns the whole link_enable_control byte
                    `SLLB_OFF_LINK_EN: st_d.rdata = st_q.link_en;
                    `SLLB_OFF_SUBCLASS: st_d.rdata = st_q.subclass;
                    `SLLB_OFF_MF_DEL_LO: st_d.rdata = st_q.mf_del_lo;
                    `SLLB_OFF_MF_DEL_HI: st_d.rdata = st_q.mf_del_hi;
                    `SLLB_OFF_MF_VAR_LO: st_d.rdata = st_q.mf_var_lo;
                    `SLLB_OFF_MF_VAR_HI: st_d.rdata = st_q.mf_var_hi;
                    `SLLB_OFF_POLARITY: st_d.rdata = st_q.polarity;
                    default: begin
                        if (bus.addr >= `SLLB_OFF_XBAR0 && bus.addr <= `SLLB_OFF_XBAR3) begin
                            st_d.rdata = st_q.xbar[bus.addr[1:0]*8 +: 8];
                        end
                    end
                endcase
            end
        end
        // ----------------------------------------------------------------
        // serial-lane pll model: locks a fixed time after enable
        // ----------------------------------------------------------------
        if (st_q.pll_en != `SLLB_PLL_ON_VAL) begin
            st_d.lock_cnt = 8'h00;
            st_d.pll_lock = 1'b0;
        end else if (st_q.lock_cnt == 8'(`SLLB_PLL_LOCK_CYC)) begin
            st_d.pll_lock = 1'b1;
        end else begin
            st_d.lock_cnt = st_q.lock_cnt + 8'h01;
        end
        // ----------------------------------------------------------------
        // frame sync machine: lock on first sysref edge after arm; re-arms from lock unless one-shot
        // ----------------------------------------------------------------
        unique case (st_q.sync)
            SY_IDLE: begin
                if (st_q.sync_ctrl[`SLLB_SYNC_EN_BIT]) begin
                    st_d.sync = SY_ENABLED;
                end
            end
            SY_ENABLED: begin
                if (!st_q.sync_ctrl[`SLLB_SYNC_EN_BIT]) begin
                    st_d.sync = SY_IDLE;
                end else if (st_q.sync_ctrl[`SLLB_SYNC_ARM_BIT]) begin
                    st_d.sync = SY_ARMED;
                end
            end
            SY_ARMED: begin
                if (!st_q.sync_ctrl[`SLLB_SYNC_EN_BIT]) begin
                    st_d.sync = SY_IDLE;
                end else if (sysref_rise) begin
                    st_d.sync = SY_LOCKED;
                    // one-shot: the arm bit clears itself once used
                    if ({6'h00, st_q.sync_ctrl[1:0]} == `SLLB_SYNC_ONESHOT) begin
                        st_d.sync_ctrl[`SLLB_SYNC_ARM_BIT] = 1'b0;
                    end
                end
            end
            SY_LOCKED: begin
                if (!st_q.sync_ctrl[`SLLB_SYNC_EN_BIT]) begin
                    st_d.sync = SY_IDLE;
                end else if (st_q.sync_ctrl[`SLLB_SYNC_ARM_BIT] && !wr_now
                    && {6'h00, st_q.sync_ctrl[1:0]} != `SLLB_SYNC_ONESHOT) begin
                    st_d.sync = SY_ARMED;
                end
            end
        endcase
        // ----------------------------------------------------------------
        // lane datapath: remap then invert, gated by the link enables
        // ----------------------------------------------------------------
        st_d.lane_out = remap(lane_stable_q, st_q.xbar) ^ st_q.polarity;
        if (st_q.link_en[1:0] == 2'h0) begin
            st_d.lane_out = 8'h00;
        end else if (!st_q.link_en[1]) begin
            st_d.lane_out[7:4] = 4'h0;
        end
        if (st_q.sysref_sync[2] == st_q.sysref_sync[1]) begin
            st_d.sysref_seen = st_q.sysref_sync[2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
            st_q.eq <= `SLLB_EQ_RESET;
            st_q.xbar <= 32'h76543210;
            st_q.sync <= SY_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign bus.ack = st_q.ack;
    assign bus.rdata = st_q.rdata;
    assign lane_out = st_q.lane_out;
    // four lanes per link; bit 2 picks the status link
    assign link_enable_mask = st_q.link_en[1:0];
    assign equalizer_setting = st_q.eq[7:6];
    assign pll_enabled = (st_q.pll_en == `SLLB_PLL_ON_VAL);
    assign pll_locked = st_q.pll_lock;
    assign sync_locked = (st_q.sync == SY_LOCKED) && st_q.link_en[`SLLB_STATUS_LINK_BIT] == 1'b0
        || (st_q.sync == SY_LOCKED) && st_q.link_en[1];
endmodule

//--- rtl/sllb_host.sv
// host end: apb-driven controller that writes the bring-up sequence
`timescale 1ns/1ns
`include "sllb_defs.svh"
module sllb_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sysref_in,
    input wire logic [7:0] lanes_in,
    sllb_if.host bus
);
    import sllb_pkg::*;

    typedef enum logic [4:0] {
        H_IDLE = 5'b00001,
        H_ISSUE = 5'b00010,
        H_WAIT = 5'b00100,
        H_POLL = 5'b01000,
        H_DONE = 5'b10000
    } sllb_hst_type;

    typedef struct packed {
        sllb_hst_type st;
        logic [3:0] step;
        logic busy;
        logic done;
        logic pll_ok;
        logic sync_ok;
        logic [1:0] equalizer_setting;
        logic two_link_select;
        logic status_link_select;
        sllb_lanes_type lane_polarity_invert;
        logic [31:0] lane_remap_values;
        sllb_addr_type rd_addr;
        sllb_byte_type rd_data;
        logic rd_go;
        logic req;
        logic wr;
        sllb_addr_type addr;
        sllb_byte_type wdata;
    } sllb_host_state_type;

    sllb_host_state_type s_q;
    sllb_host_state_type s_d;

    // next write of the bring-up script; poll steps are reads of lock bits
    function automatic logic [20:0] script(input logic [3:0] k, input sllb_host_state_type s);
        unique case (k)
            4'd0: return {1'b1, `SLLB_OFF_VARACTOR, `SLLB_VARACTOR_VAL};
            4'd1: return {1'b1, `SLLB_OFF_PLL_EN, `SLLB_PLL_ON_VAL};
            4'd2: return {1'b0, `SLLB_OFF_PLL_LOCK, 8'h00};
            4'd3: return {1'b1, `SLLB_OFF_EQ, s.equalizer_setting, `SLLB_EQ_REQ_VAL};
            4'd4: return {1'b1, `SLLB_OFF_SYNC_CTRL, `SLLB_SYNC_ONESHOT};
            4'd5: return {1'b1, `SLLB_OFF_SYNC_CTRL, `SLLB_SYNC_ENABLE};
            4'd6: return {1'b1, `SLLB_OFF_SYNC_CTRL, `SLLB_SYNC_ARM};
            4'd7: return {1'b0, `SLLB_OFF_SYNC_STAT, 8'h00};
            4'd8: return {1'b1, `SLLB_OFF_XBAR0, s.lane_remap_values[7:0]};
            4'd9: return {1'b1, 12'h309, s.lane_remap_values[15:8]};
            4'd10: return {1'b1, 12'h30a, s.lane_remap_values[23:16]};
            4'd11: return {1'b1, `SLLB_OFF_XBAR3, s.lane_remap_values[31:24]};
            4'd12: return {1'b1, `SLLB_OFF_POLARITY, s.lane_polarity_invert};
            // link enable last so links start from a settled setup
            default: return {1'b1, `SLLB_OFF_LINK_EN, 4'h0, s.two_link_select,
                s.status_link_select, s.two_link_select ? `SLLB_LINKS_DUAL
                : `SLLB_LINKS_SINGLE};
        endcase
    endfunction

    logic acc;
    logic [20:0] cmd;
    assign acc = psel && penable;
    assign cmd = script(s_q.step, s_q);

    always_comb begin
        s_d = s_q;
        s_d.rd_go = 1'b0;
        // ----------------------------------------------------------------
        // apb slave: zero-wait writes in the access phase
        // ----------------------------------------------------------------
        if (acc && pwrite) begin
            unique case (paddr)
                `SLLB_APB_CMD: begin
                    if (pwdata[0] && !s_q.busy) begin
                        s_d.busy = 1'b1;
                        s_d.done = 1'b0;
                        s_d.step = 4'd0;
                        s_d.st = H_ISSUE;
                    end
                end
                `SLLB_APB_LINKCFG: begin
                    s_d.two_link_select = pwdata[0];
                    s_d.status_link_select = pwdata[1];
                    s_d.equalizer_setting = pwdata[5:4];
                    s_d.lane_polarity_invert = pwdata[15:8];
                end
                `SLLB_APB_XBAR: s_d.lane_remap_values = pwdata;
                `SLLB_APB_RDADDR: begin
                    s_d.rd_addr = pwdata[11:0];
                    s_d.rd_go = !s_q.busy;
                end
                default: begin
                end
            endcase
        end
        // ----------------------------------------------------------------
        // sequencer on the device register port
        // ----------------------------------------------------------------
        unique case (s_q.st)
            H_IDLE: begin
                if (s_q.rd_go) begin
                    s_d.req = 1'b1;
                    s_d.wr = 1'b0;
                    s_d.addr = s_q.rd_addr;
                    s_d.st = H_POLL;
                    s_d.step = 4'd15;
                end
            end
            H_ISSUE: begin
                s_d.req = 1'b1;
                s_d.wr = cmd[20];
                s_d.addr = cmd[19:8];
                s_d.wdata = cmd[7:0];
                s_d.st = cmd[20] ? H_WAIT : H_POLL;
            end
            H_WAIT: begin
                if (bus.ack) begin
                    s_d.req = 1'b0;
                    s_d.step = s_q.step + 4'd1;
                    s_d.st = (s_q.step == 4'd13) ? H_DONE : H_ISSUE;
                end
            end
            H_POLL: begin
                if (bus.ack) begin
                    s_d.req = 1'b0;
                    s_d.rd_data = bus.rdata;
                    s_d.st = H_ISSUE;
                    if (s_q.step == 4'd15) begin
                        s_d.st = H_IDLE;
                        s_d.step = 4'd0;
                    end else if (s_q.step == 4'd2 && bus.rdata[0]) begin
                        s_d.pll_ok = 1'b1;
                        s_d.step = 4'd3;
                    end else if (s_q.step == 4'd7 && bus.rdata[`SLLB_LOCK_BIT]) begin
                        s_d.sync_ok = 1'b1;
                        s_d.step = 4'd8;
                    end
                end
            end
            H_DONE: begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.st <= H_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            `SLLB_APB_STAT: prdata = {28'h0, s_q.sync_ok, s_q.pll_ok, s_q.done, s_q.busy};
            `SLLB_APB_LINKCFG: prdata = {16'h0, s_q.lane_polarity_invert, 2'h0,
                s_q.equalizer_setting, 2'h0, s_q.status_link_select, s_q.two_link_select};
            `SLLB_APB_XBAR: prdata = s_q.lane_remap_values;
            `SLLB_APB_RDADDR: prdata = {20'h0, s_q.rd_addr};
            `SLLB_APB_RDDATA: prdata = {24'h0, s_q.rd_data};
            default: prdata = 32'h0000_0000;
        endcase
    end
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign bus.req = s_q.req;
    assign bus.wr = s_q.wr;
    assign bus.addr = s_q.addr;
    assign bus.wdata = s_q.wdata;
    // sysref and lane data are forwarded from the transmitter side
    assign bus.sysref = sysref_in;
    assign bus.lane_data = lanes_in;
endmodule

//--- test/sllb_link_sva.sv
// checker for the register port joining host and device ends
`timescale 1ns/1ns
`include "sllb_defs.svh"
module sllb_link_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req,
    input wire logic wr,
    input wire sllb_pkg::sllb_addr_type addr,
    input wire sllb_pkg::sllb_byte_type wdata,
    input wire logic ack,
    input wire sllb_pkg::sllb_byte_type rdata,
    input wire logic sysref,
    input wire sllb_pkg::sllb_lanes_type lane_data
);
    import sllb_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic hit_w;
    logic pll_on_q;
    logic [5:0] pll_cnt_q;
    sllb_byte_type eq_q;
    sllb_byte_type sync_q;
    logic ref_q;
    assign hit_w = req && wr && ack;
    // ----------------------------------------
    // shadow state
    // ----------------------------------------
    // ref_q stays set: a re-arm may find the lock flag still up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_on_q <= 1'b0;
            pll_cnt_q <= 6'h00;
            eq_q <= `SLLB_EQ_RESET;
            sync_q <= 8'h00;
            ref_q <= 1'b0;
        end else begin
            if (pll_on_q && pll_cnt_q != 6'h3f) pll_cnt_q <= pll_cnt_q + 6'h01;
            if (hit_w && addr == `SLLB_OFF_PLL_EN) begin
                pll_on_q <= (wdata == `SLLB_PLL_ON_VAL);
                if (!pll_on_q || wdata != `SLLB_PLL_ON_VAL) pll_cnt_q <= 6'h00;
            end
            if (hit_w && addr == `SLLB_OFF_EQ) eq_q <= wdata;
            if (hit_w && addr == `SLLB_OFF_SYNC_CTRL) sync_q <= wdata;
            if (hit_w && addr == `SLLB_OFF_SYNC_CTRL && wdata == `SLLB_SYNC_ARM && sysref)
                ref_q <= 1'b1;
            if (sync_q == `SLLB_SYNC_ARM && $rose(sysref)) ref_q <= 1'b1;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    sequence s_wr(sllb_addr_type a);
        req && wr && ack && addr == a;
    endsequence
    sequence s_rd(sllb_addr_type a);
        req && !wr && ack && addr == a;
    endsequence
    chk_ack_one_cycle: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    chk_req_answered: assert property (req && !ack |=> ack && req && $stable(addr)
        && $stable(wdata) && $stable(wr)) else $error("request not answered next cycle");
    chk_pll_on_value: assert property (
        req && wr && addr == `SLLB_OFF_PLL_EN |-> wdata == 8'h01)
        else $error("bad pll enable value");
    chk_pll_lock_flag: assert property (
        s_rd(`SLLB_OFF_PLL_LOCK) ##0 (pll_cnt_q < 6'd20 || pll_cnt_q > 6'd30)
        |-> rdata[0] == (pll_cnt_q > 6'd30))
        else $error("pll lock flag wrong");
    chk_eq_low_bits: assert property (
        req && wr && addr == `SLLB_OFF_EQ |-> wdata[5:0] == 6'h22)
        else $error("equalizer low bits wrong");
    chk_eq_readback: assert property (s_rd(`SLLB_OFF_EQ) |-> rdata == eq_q)
        else $error("equalizer readback wrong");
    chk_varactor_val: assert property (
        req && wr && addr == `SLLB_OFF_VARACTOR |-> wdata == 8'h06)
        else $error("varactor value wrong");
    chk_sync_step_order: assert property (
        s_wr(`SLLB_OFF_SYNC_CTRL) |-> wdata == 8'h01 || (wdata == 8'h81 && sync_q == 8'h01)
        || (wdata == 8'hc1 && sync_q == 8'h81))
        else $error("sync control steps out of order");
    chk_sync_lock_cause: assert property (
        s_rd(`SLLB_OFF_SYNC_STAT) ##0 rdata[3] |-> ref_q)
        else $error("sync lock without sysref edge");
    chk_link_en_field: assert property (
        s_wr(`SLLB_OFF_LINK_EN) |-> wdata[1:0] == (wdata[3] ? 2'h3 : 2'h1))
        else $error("link enable field wrong");
    chk_link_en_last: assert property (
        s_wr(`SLLB_OFF_LINK_EN) |-> ref_q && pll_cnt_q > 6'd30)
        else $error("links enabled before setup done");
endmodule

//--- test/testbench.sv
// bench: apb traffic into the host end, device outputs and readbacks compared
`timescale 1ns/1ns
`include "sllb_defs.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench;
    import sllb_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sysref_in = 1'b0;
    logic [7:0] lanes_in = 8'h00;
    logic [7:0] lane_out;
    logic [1:0] link_enable_mask;
    logic [1:0] equalizer_setting;
    logic pll_enabled;
    logic pll_locked;
    logic sync_locked;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [31:0] q;
    logic [7:0] b;
    sllb_if bus_if ();
    always #4 pclk = ~pclk;
    sllb_host i_sllb_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sysref_in(sysref_in), .lanes_in(lanes_in), .bus(bus_if));
    sllb_device i_sllb_device (.pclk(pclk), .presetn(presetn), .bus(bus_if),
        .lane_out(lane_out), .link_enable_mask(link_enable_mask),
        .equalizer_setting(equalizer_setting), .pll_enabled(pll_enabled),
        .pll_locked(pll_locked), .sync_locked(sync_locked));
    sllb_link_sva u_chk (.pclk(pclk), .presetn(presetn), .req(bus_if.req), .wr(bus_if.wr),
        .addr(bus_if.addr), .wdata(bus_if.wdata), .ack(bus_if.ack), .rdata(bus_if.rdata),
        .sysref(bus_if.sysref), .lane_data(bus_if.lane_data));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // periodic sysref, so an edge always follows arming
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        sysref_in <= (cyc % 64) < 4;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic dev_rd(input logic [11:0] a);
        apb(1'b1, `SLLB_APB_RDADDR, {20'h0, a});
        for (int i = 0; i < 50; i++) begin
            apb(1'b0, `SLLB_APB_STAT, 32'h0);
            if (q[0] === 1'b0) break;
        end
        apb(1'b0, `SLLB_APB_RDDATA, 32'h0);
        b = q[7:0];
    endtask
    task automatic run_seq(input logic [31:0] cfg);
        apb(1'b1, `SLLB_APB_LINKCFG, cfg);
        apb(1'b1, `SLLB_APB_CMD, 32'h1);
        for (int i = 0; i < 500; i++) begin
            apb(1'b0, `SLLB_APB_STAT, 32'h0);
            if (q[1:0] === 2'b10) break;
        end
        `CHK("status", 4'he, q[3:0])
    endtask
    // crossbar 0x01234567: logical lane i takes physical lane 7-i
    task automatic lane_chk(input logic [7:0] pol, input logic [7:0] msk);
        logic [7:0] e;
        foreach (e[i]) e[i] = 1'b0;
        for (int p = 0; p < 2; p++) begin
            lanes_in <= p ? 8'h01 : 8'hc6;
            repeat (8) @(posedge pclk);
            for (int i = 0; i < 8; i++) e[i] = (lanes_in[7 - i] ^ pol[i]) & msk[i];
            `CHK("lane_out", e, lane_out)
        end
    endtask
    logic [11:0] ra [6] = '{12'h268, 12'h300, 12'h334, 12'h2a0, 12'h280, 12'h03a};
    logic [7:0] rv [6] = '{8'ha2, 8'h0b, 8'h5a, 8'h06, 8'h01, 8'h81};
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        dev_rd(`SLLB_OFF_EQ);
        `CHK("eq reset", 8'h22, b)
        dev_rd(`SLLB_OFF_PLL_LOCK);
        `CHK("lock early", 1'b0, b[0])
        dev_rd(12'h123);
        `CHK("unmapped", 8'h00, b)
        `CHK("links off", 2'b00, link_enable_mask)
        apb(1'b1, `SLLB_APB_XBAR, 32'h01234567);
        run_seq(32'h00005a21);
        `CHK("dual links", 2'b11, link_enable_mask)
        `CHK("eq", 2'b10, equalizer_setting)
        `CHK("flags", 3'b111, {pll_enabled, pll_locked, sync_locked})
        lane_chk(8'h5a, 8'hff);
        for (int i = 0; i < 6; i++) begin
            dev_rd(ra[i]);
            `CHK("readback", rv[i], b)
        end
        dev_rd(`SLLB_OFF_SYNC_STAT);
        `CHK("sync lock", 1'b1, b[3])
        run_seq(32'h00000322);
        `CHK("single link", 2'b01, link_enable_mask)
        `CHK("flags1", 3'b110, {pll_enabled, pll_locked, sync_locked})
        dev_rd(`SLLB_OFF_LINK_EN);
        `CHK("link ctl", 8'h05, b)
        lane_chk(8'h03, 8'h0f);
        `CHK("slverr", 1'b0, pslverr)
        report_and_stop();
    end
endmodule
